// File: tb/far_unit.sv
// Behavioural far-end instrument sharing the sync-off line
`timescale 1ns/1ps
module far_unit
  import sync_off_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic line,
  input wire logic send,
  input wire logic [15:0] len,
  input wire logic turn_on,
  output logic drv_low,
  output logic far_on
);
  logic [15:0] tx_r;
  logic [15:0] rx_r;
  assign drv_low = tx_r != 16'h0000;
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      far_on <= 1'b0;
    end else begin
      if (send) tx_r <= len;
      else if (drv_low) tx_r <= tx_r - 16'h0001;
      rx_r <= (!line && !drv_low) ? rx_r + 16'h0001 : 16'h0000;
      if (turn_on) far_on <= 1'b1;
      else if (rx_r == pulse_cycles - 16'h0001) far_on <= 1'b0;
    end
  end
endmodule

// File: tb/tb.sv
// Testbench for the sync-off I/O pin block
`timescale 1ns/1ps
module tb import sync_off_pkg::*;;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, output_on;
  logic [1:0] bresp, rresp;
  logic panel_on = 1'b0, panel_off = 1'b0, send = 1'b0, turn_on = 1'b0, drv_low, far_on;
  logic [15:0] len = 16'h0000;
  wire pin = drv_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  int n_errors = 0, cmp_count = 0, c;
  initial forever #5 clock = ~clock;
  sync_off_io_pin u_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .panel_on(panel_on),
    .panel_off(panel_off), .pin_in(pin), .pin_out(pin_out), .pin_oe(pin_oe),
    .output_on(output_on));
  far_unit u_far (.clock(clock), .rst(rst), .line(pin), .send(send), .len(len),
    .turn_on(turn_on), .drv_low(drv_low), .far_on(far_on));
  // ==========================================
  // Shared tasks
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tmo;
    n_errors++;
    $display("unexpected bus wait expected answer seen none");
    print_verdict;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        chk("bresp", 32'h0, 32'(bresp));
        return;
      end
    end
    tmo;
  endtask
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] re);
    logic ha, hr;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      ha = arvalid && arready;
      hr = rvalid && rready;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        chk("rdata", e, rdata & m);
        chk("rresp", 32'(re), 32'(rresp));
        return;
      end
    end
    tmo;
  endtask
  task cnt(input int w);
    c = 0;
    for (int n = 0; n < w; n++) begin
      @(negedge clock);
      if (pin_oe === 1'b1 && pin === 1'b0) c++;
    end
  endtask
  task far_pulse(input logic [15:0] l);
    @(posedge clock);
    send <= 1'b1;
    len <= l;
    @(posedge clock);
    send <= 1'b0;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    axr(ctrl_off, 32'h0, 32'hffffffff, 2'h0);
    axr(pwm_period_off, pwm_period_rst, 32'hffffffff, 2'h0);
    axr(pwm_high_off, pwm_high_rst, 32'hffffffff, 2'h0);
    axr(status_off, 32'h8, 32'h9, 2'h0);
    axr(8'h10, 32'h0, 32'hffffffff, 2'h2);
    $display("test reset done");
    turn_on <= 1'b1;
    axw(ctrl_off, 32'h20);
    turn_on <= 1'b0;
    #1 chk("output_on", 32'h1, 32'(output_on));
    chk("far_on", 32'h1, 32'(far_on));
    @(posedge clock);
    panel_off <= 1'b1;
    @(posedge clock);
    panel_off <= 1'b0;
    cnt(4000);
    chk("tx width", 32'(pulse_cycles), 32'(c));
    chk("output_on", 32'h0, 32'(output_on));
    chk("far_on", 32'h0, 32'(far_on));
    $display("test send done");
    @(posedge clock);
    panel_on <= 1'b1;
    @(posedge clock);
    panel_on <= 1'b0;
    #1 chk("output_on", 32'h1, 32'(output_on));
    axr(status_off, 32'h1, 32'h1, 2'h0);
    far_pulse(16'd2000);
    repeat (2600) @(posedge clock);
    #1 chk("output_on", 32'h1, 32'(output_on));
    axr(status_off, 32'h1, 32'h5, 2'h0);
    far_pulse(pulse_cycles);
    repeat (3100) @(posedge clock);
    #1 chk("output_on", 32'h0, 32'(output_on));
    axr(status_off, 32'h4, 32'h5, 2'h0);
    repeat (3100) @(posedge clock);
    far_pulse(pulse_cycles);
    repeat (3100) @(posedge clock);
    #1 chk("output_on", 32'h0, 32'(output_on));
    chk("pin_oe", 32'h0, 32'(pin_oe));
    $display("test receive done");
    for (int i = 0; i < 4; i++) begin
      axw(ctrl_off, 32'(2 + 8 * (i % 2) + 4 * (i / 2)));
      #1 chk("pin level", 32'(~((i % 2) ^ (i / 2)) & 1), 32'(pin));
      chk("pin_oe", 32'h1, 32'(pin_oe));
    end
    axw(pwm_period_off, 32'h0000000a);
    axw(pwm_high_off, 32'h00000004);
    axw(ctrl_off, 32'h12);
    repeat (20) @(posedge clock);
    cnt(10);
    chk("pwm active", 32'h4, 32'(c));
    $display("test output done");
    axw(ctrl_off, 32'h1);
    axr(status_off, 32'h0, 32'h2, 2'h0);
    far_pulse(pulse_cycles);
    repeat (100) @(posedge clock);
    axr(status_off, 32'h2, 32'h2, 2'h0);
    #1 chk("pin_oe", 32'h0, 32'(pin_oe));
    repeat (3000) @(posedge clock);
    axw(ctrl_off, 32'h5);
    axr(status_off, 32'h2, 32'h2, 2'h0);
    $display("test input done");
    print_verdict;
  end
endmodule

// File: verilog/pwm_gen.sv
// PWM waveform generator with programmable period and high time
`timescale 1ns/1ps
module pwm_gen
  import sync_off_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] period,
  input wire logic [31:0] high_time,
  output logic pwm
);
  typedef struct packed {
    logic [31:0] cnt;
    logic pwm;
  } pwm_state_type;

  pwm_state_type s_r;
  pwm_state_type s_nxt;

  // ==========================================
  // Counter and compare
  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt + 32'h1 >= period) begin
      s_nxt.cnt = 32'h0;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
    s_nxt.pwm = (s_nxt.cnt < high_time);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm = s_r.pwm;
endmodule

// File: verilog/sync_off_io_pin.sv
// Sync-off / input / output pin logic with AXI4-Lite control registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Modes: sync turn-off default, input, output
// - Invert bit flips pin input and output
// - Sync mode both sends and receives pulses
// - Input mode samples external level into status
// - Output true drives logic one, low normally
// - Output false drives logic zero, high normally
// - Output PWM with settable period and duty
// - Pulses hold low at least 30 us, high when inverted
// - Output on-to-off transition in sync mode emits a pulse
// - Received pulse while off only sets the rx status flag
// - Received pulse while on turns output off
// - Linked units turn off together via pulses
module sync_off_io_pin
  import sync_off_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic panel_on,
  input wire logic panel_off,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic output_on
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic bslverr;
    logic rvalid;
    logic rslverr;
    logic [31:0] rdata;
    mode_type mode;
    logic invert;
    logic out_val;
    logic out_pwm;
    logic [31:0] pwm_period;
    logic [31:0] pwm_high;
    logic out_on;
    logic sync1;
    logic sync2;
    logic [15:0] low_cnt;
    logic rx_armed;
    logic rx_sticky;
    logic [15:0] tx_cnt;
    logic level;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic pwm_wave;
  logic logic_in;
  logic rx_pulse;
  logic wr_fire;
  logic rd_fire;
  logic on_req;
  logic off_req;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ctrl_off) || (a == status_off) || (a == pwm_period_off)
      || (a == pwm_high_off);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  pwm_gen u_pwm (
    .clock(clock),
    .rst(rst),
    .period(s_r.pwm_period),
    .high_time(s_r.pwm_high),
    .pwm(pwm_wave)
  );

  // ==========================================
  // Bus handshakes
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bslverr ? 2'h2 : 2'h0;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rslverr ? 2'h2 : 2'h0;
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Pin polarity: active-low logic, inverted when invert is set
  assign logic_in = s_r.invert ? s_r.sync2 : !s_r.sync2;
  assign rx_pulse = (s_r.mode == mode_sync_off) && s_r.rx_armed
    && (s_r.low_cnt == pulse_cycles - 16'h1) && logic_in;
  assign on_req = wr_fire && mapped(s_r.aw_addr) && (s_r.aw_addr == ctrl_off)
    && s_r.w_strb[0] && s_r.w_data[on_req_bit];
  assign off_req = wr_fire && (s_r.aw_addr == ctrl_off) && s_r.w_strb[0]
    && s_r.w_data[off_req_bit];

  // ==========================================
  // Next state
  always_comb begin
    logic [31:0] ctl;
    ctl = '0;
    s_nxt = s_r;
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bslverr = !mapped(s_r.aw_addr);
      ctl = merge({25'h0, 1'b0, 1'b0, s_r.out_pwm, s_r.out_val, s_r.invert, s_r.mode},
        s_r.w_data, s_r.w_strb);
      case (s_r.aw_addr)
        ctrl_off: begin
          if (s_r.w_strb[0]) begin
            if (ctl[mode_lsb +: 2] == 2'h3) begin
              s_nxt.mode = s_r.mode;
            end else begin
              s_nxt.mode = mode_type'(ctl[mode_lsb +: 2]);
            end
            s_nxt.invert = ctl[invert_bit];
            s_nxt.out_val = ctl[out_val_bit];
            s_nxt.out_pwm = ctl[out_pwm_bit];
          end
        end
        pwm_period_off: begin
          s_nxt.pwm_period = merge(s_r.pwm_period, s_r.w_data, s_r.w_strb);
        end
        pwm_high_off: begin
          s_nxt.pwm_high = merge(s_r.pwm_high, s_r.w_data, s_r.w_strb);
        end
        default: begin
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (rd_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rslverr = !mapped(s_axi_araddr);
      case (s_axi_araddr)
        ctrl_off: begin
          s_nxt.rdata = {27'h0, s_r.out_pwm, s_r.out_val, s_r.invert, s_r.mode};
        end
        status_off: begin
          s_nxt.rdata = {28'h0, s_r.sync2, s_r.rx_sticky, s_r.level, s_r.out_on};
          s_nxt.rx_sticky = 1'b0;
        end
        pwm_period_off: begin
          s_nxt.rdata = s_r.pwm_period;
        end
        pwm_high_off: begin
          s_nxt.rdata = s_r.pwm_high;
        end
        default: begin
          s_nxt.rdata = 32'h0;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Input synchroniser
    s_nxt.sync1 = pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.level = logic_in;
    // Low-width filter; pulse counted once per low period
    if (!logic_in || s_r.mode != mode_sync_off) begin
      s_nxt.low_cnt = 16'h0;
      s_nxt.rx_armed = 1'b1;
    end else if (s_r.rx_armed) begin
      if (s_r.low_cnt == pulse_cycles - 16'h1) begin
        s_nxt.rx_armed = 1'b0;
      end else begin
        s_nxt.low_cnt = s_r.low_cnt + 16'h1;
      end
    end
    if (rx_pulse) begin
      s_nxt.rx_sticky = 1'b1;
    end
    // Output on/off state
    if (panel_on || on_req) begin
      s_nxt.out_on = 1'b1;
    end
    if (panel_off || off_req) begin
      s_nxt.out_on = 1'b0;
    end
    if (rx_pulse && s_r.out_on) begin
      s_nxt.out_on = 1'b0;
    end
    // Transmit a pulse on every on-to-off change while in sync-off mode
    if (s_r.tx_cnt != 16'h0) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
    end
    if (s_r.mode == mode_sync_off && s_r.out_on && !s_nxt.out_on) begin
      s_nxt.tx_cnt = pulse_cycles;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.mode <= mode_sync_off;
      s_r.pwm_period <= pwm_period_rst;
      s_r.pwm_high <= pwm_high_rst;
      s_r.low_cnt <= 16'h0;
      s_r.rx_armed <= 1'b1;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Pin drive
  logic drive_logic;
  always_comb begin
    drive_logic = 1'b0;
    pin_oe = 1'b0;
    case (s_r.mode)
      mode_sync_off: begin
        drive_logic = (s_r.tx_cnt != 16'h0);
        pin_oe = drive_logic;
      end
      mode_output: begin
        drive_logic = s_r.out_pwm ? pwm_wave : s_r.out_val;
        pin_oe = 1'b1;
      end
      default: begin
        drive_logic = 1'b0;
        pin_oe = 1'b0;
      end
    endcase
  end
  assign pin_out = s_r.invert ? drive_logic : !drive_logic;
  assign output_on = s_r.out_on;

  // ==========================================
  // Assertions
  sequence tx_start;
    s_r.mode == mode_sync_off && s_r.out_on && !s_nxt.out_on;
  endsequence

  sequence tx_loaded;
    (s_r.tx_cnt == pulse_cycles) ##1 (s_r.tx_cnt == pulse_cycles - 16'h1);
  endsequence

  sequence tx_running;
    s_r.mode == mode_sync_off && s_r.tx_cnt != 16'h0;
  endsequence

  sequence mode3_write;
    wr_fire && s_r.aw_addr == ctrl_off && s_r.w_strb[0]
      && s_r.w_data[mode_lsb +: 2] == 2'h3;
  endsequence

  a_tx_pulse_width: assert property (@(posedge clock) disable iff (rst)
    tx_start |=> tx_loaded)
    else $error("tx pulse not loaded to full width");
  a_off_emits: assert property (@(posedge clock) disable iff (rst)
    tx_start |=> (pin_oe && pin_out == s_r.invert))
    else $error("turn-off did not drive pulse");
  a_tx_held_low: assert property (@(posedge clock) disable iff (rst)
    tx_running |-> pin_oe && pin_out == s_r.invert)
    else $error("tx pulse released early");
  a_tx_released: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_sync_off && s_r.tx_cnt == 16'h0 |-> !pin_oe)
    else $error("sync pin driven while idle");
  a_tx_cause: assert property (@(posedge clock) disable iff (rst)
    $rose(s_r.tx_cnt != 16'h0) |-> $past(s_r.out_on) && !s_r.out_on)
    else $error("pulse sent without turn-off");
  a_panel_off_wins: assert property (@(posedge clock) disable iff (rst)
    panel_off |=> !output_on)
    else $error("panel off did not turn output off");
  a_rx_turns_off: assert property (@(posedge clock) disable iff (rst)
    rx_pulse && output_on |=> !output_on)
    else $error("received pulse did not turn output off");
  a_rx_off_stays: assert property (@(posedge clock) disable iff (rst)
    rx_pulse && !output_on && !panel_on && !on_req |=> !output_on)
    else $error("received pulse changed off state");
  a_rx_no_echo: assert property (@(posedge clock) disable iff (rst)
    rx_pulse && !output_on |=> !$rose(s_r.tx_cnt != 16'h0))
    else $error("received pulse while off started a pulse");
  a_rx_once: assert property (@(posedge clock) disable iff (rst)
    rx_pulse |=> !rx_pulse)
    else $error("one low period gave two pulses");
  a_rx_sticky_set: assert property (@(posedge clock) disable iff (rst)
    rx_pulse |=> s_r.rx_sticky)
    else $error("received pulse not flagged");
  a_true_drives_low: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_output && !s_r.out_pwm && s_r.out_val |-> pin_oe
      && (pin_out == s_r.invert))
    else $error("output true level wrong");
  a_false_drives_high: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_output && !s_r.out_pwm && !s_r.out_val |-> pin_oe
      && (pin_out != s_r.invert))
    else $error("output false level wrong");
  a_pwm_drives: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_output && s_r.out_pwm |-> pin_oe
      && ((pin_out == s_r.invert) == pwm_wave))
    else $error("pwm level wrong");
  a_input_no_drive: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_input |-> !pin_oe)
    else $error("pin driven in input mode");
  a_level_follows: assert property (@(posedge clock) disable iff (rst)
    s_r.mode == mode_input |=> s_r.level == $past(logic_in))
    else $error("input level not captured");
  a_mode3_ignored: assert property (@(posedge clock) disable iff (rst)
    mode3_write |=> $stable(s_r.mode))
    else $error("reserved mode code changed mode");
  a_rx_needs_width: assert property (@(posedge clock) disable iff (rst)
    rx_pulse |-> s_r.low_cnt == pulse_cycles - 16'h1 && $past(logic_in)
      && $stable(s_r.mode))
    else $error("pulse accepted before minimum width");
  a_sync_default: assert property (@(posedge clock)
    $past(rst) && !rst |-> s_r.mode == mode_sync_off && !output_on && !pin_oe)
    else $error("mode not sync-off after reset");
endmodule

// File: verilog/sync_off_pkg.sv
// Package with constants and types for the sync-off I/O pin block
package sync_off_pkg;
  // ==========================================
  // Register map (byte offsets)
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] pwm_period_off = 8'h08;
  localparam logic [7:0] pwm_high_off = 8'h0c;
  // ==========================================
  // Field positions
  localparam int mode_lsb = 0;
  localparam int invert_bit = 2;
  localparam int out_val_bit = 3;
  localparam int out_pwm_bit = 4;
  localparam int on_req_bit = 5;
  localparam int off_req_bit = 6;
  localparam int st_on_bit = 0;
  localparam int st_level_bit = 1;
  localparam int st_rx_bit = 2;
  localparam int st_pin_bit = 3;
  // ==========================================
  // Reset values
  localparam logic [31:0] pwm_period_rst = 32'h0000_0064;
  localparam logic [31:0] pwm_high_rst = 32'h0000_0032;
  // ==========================================
  // Timing
  localparam int clk_mhz = 100;
  localparam int pulse_min_us = 30;
  localparam logic [15:0] pulse_cycles = 16'((pulse_min_us * clk_mhz));
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    mode_sync_off,
    mode_input,
    mode_output
  } mode_type;
endpackage
